// ### hdl/dpram_consts.vh
`ifndef DPRAM_CONSTS_VH
`define DPRAM_CONSTS_VH

// write modes
`define DPRAM_WM_NEW_FIRST   2'h0
`define DPRAM_WM_HOLD_OUT    2'h1
`define DPRAM_WM_OLD_FIRST   2'h2

// cascade position
`define DPRAM_CASC_NONE      2'h0
`define DPRAM_CASC_FIRST     2'h1
`define DPRAM_CASC_MIDDLE    2'h2
`define DPRAM_CASC_LAST      2'h3

// output-stage reset precedence
`define DPRAM_PREC_RESET     1'b0
`define DPRAM_PREC_CLK_EN    1'b1

// port clock sharing
`define DPRAM_CLK_INDEPENDENT 1'b0
`define DPRAM_CLK_COMMON      1'b1

// geometry: words of 64 data + 8 parity bits
`define DPRAM_WORDS_SMALL    256
`define DPRAM_WORDS_LARGE    512
`define DPRAM_VEC_BITS       256
`define DPRAM_DATA_BITS      32768
`define DPRAM_PAR_BITS       4096
`define DPRAM_KEY_PERIOD     12

// reset / init constant defaults
`define DPRAM_CONST_RESET    72'h00_0000_0000_0000_0000
`define DPRAM_CONTENT_RESET  32768'h0
`define DPRAM_PARITY_RESET   4096'h0

// wake-up after powerdown release, in clock cycles
`define DPRAM_WAKE_CYCLES    2'h2

`endif

// ### hdl/dpram_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dpram_consts.vh"

module dpram_port #(
  parameter        DW_LOG     = 0,
  parameter        HAS_PAR    = 0,
  parameter        PIPE       = 1,
  parameter        CE_FIRST   = 0,
  parameter [1:0]  WMODE      = `DPRAM_WM_NEW_FIRST,
  parameter [71:0] RST_CONST  = `DPRAM_CONST_RESET,
  parameter [71:0] INIT_CONST = `DPRAM_CONST_RESET,
  parameter [1:0]  CASC       = `DPRAM_CASC_NONE,
  parameter        ADDR_HOLD  = 0
) (
  input  wire        clk,        // port clock
  input  wire        rst_n,      // configuration reset
  input  wire        active,     // memory awake and port in use
  input  wire        en,         // port enable
  input  wire        we,         // write strobe
  input  wire [14:0] addr,       // entry address
  input  wire        addr_cap,   // address capture enable
  input  wire [63:0] rd_word,    // memory data shifted to bit 0
  input  wire [7:0]  rd_par,     // memory parity shifted to bit 0
  input  wire [63:0] din,        // write data
  input  wire [7:0]  parity_write_bus,       // write parity
  input  wire        srst,       // output stage sync reset
  input  wire        ce,         // output stage clock enable
  input  wire [71:0] casc_in,    // lower memory output
  input  wire        casc_sel,   // take lower memory output
  output wire [14:0] eff_addr,   // address used this cycle
  output wire [63:0] dmask,      // data lane mask
  output wire [7:0]  pmask,      // parity lane mask
  output wire [63:0] dout,       // read data
  output wire [7:0]  parity_read_bus       // read parity
);
  localparam DW = 1 << DW_LOG;
  localparam PW = HAS_PAR ? (DW >> 3) : 0;
  localparam [63:0] DM = {64{1'b1}} >> (64 - DW);
  localparam [7:0]  PM = HAS_PAR ? (8'hFF >> (8 - PW)) : 8'h00;
  localparam [71:0] RST_HI  = RST_CONST >> DW;
  localparam [71:0] INIT_HI = INIT_CONST >> DW;
  localparam [71:0] RST_V  = {RST_HI[7:0] & PM, RST_CONST[63:0] & DM};
  localparam [71:0] INIT_V = {INIT_HI[7:0] & PM, INIT_CONST[63:0] & DM};
  localparam CASC_TAKE = (CASC == `DPRAM_CASC_MIDDLE) || (CASC == `DPRAM_CASC_LAST);

  reg  [14:0] held_addr;
  reg  [71:0] out_latch;
  reg  [71:0] out_reg;
  wire [71:0] rd_v = {rd_par & PM, rd_word & DM};
  wire [71:0] wr_v = {parity_write_bus & PM, din & DM};

  assign dmask    = DM;
  assign pmask    = PM;
  // low capture enable reuses last captured address [RL13]
  assign eff_addr = (ADDR_HOLD && !addr_cap) ? held_addr : addr;
  // pipeline adds one cycle; latch is visible right after the access edge [RL20]
  assign dout     = PIPE ? out_reg[63:0] : out_latch[63:0];
  assign parity_read_bus    = PIPE ? out_reg[71:64] : out_latch[71:64];

  always @(posedge clk)
  begin
    if (!rst_n)
      held_addr <= 15'h0000;
    else if (addr_cap)
      held_addr <= addr;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      out_latch <= INIT_V;                          // [RL18]
    else if (active && en)
    begin
      if (!PIPE && srst)
        out_latch <= RST_V;                         // [RL5] [RL6]
      else if (CASC_TAKE && casc_sel)
        out_latch <= casc_in;                       // [RL11]
      else if (!we)
        out_latch <= rd_v;
      else
      begin
        case (WMODE)                                // [RL7] [RL21]
          `DPRAM_WM_NEW_FIRST: out_latch <= wr_v;
          `DPRAM_WM_OLD_FIRST: out_latch <= rd_v;
          default:             out_latch <= out_latch;
        endcase
      end
    end
  end

  // reset wins unless clock-enable precedence was chosen
  always @(posedge clk)
  begin
    if (!rst_n)
      out_reg <= INIT_V;                            // [RL18]
    else if (PIPE)
    begin
      if (srst && (!CE_FIRST || ce))
        out_reg <= RST_V;                           // [RL1] [RL2] [RL5]
      else if (ce)
        out_reg <= out_latch;
    end
  end
endmodule // dpram_port

// Operation
// RL1: per-port reset or clock-enable precedence, reset default
// RL2: with enable precedence, reset needs enable high
// RL3: powerdown input synchronous by default, else asynchronous
// RL4: user idles enables around powerdown and wake
// RL5: sync reset loads per-port reset constant
// RL6: without pipeline, reset loads the output latch
// RL7: write modes new-first, hold-output, old-first
// RL8: simple dual-port needs equal write modes
// RL9: port A widths 0..18, 36 large, not simple
// RL10: port B widths to 36, 72 simple large
// RL11: cascade position first, middle, last or none
// RL12: clocks common only when tied to one source
// RL13: low capture enable reuses previous address
// RL14: content zero default, 64 or 128 vectors
// RL15: vector n covers bits n*256 upward
// RL16: parity content zero default, 8 or 16 vectors
// RL17: rolling-key slots always start at zero
// RL18: output stage takes initial constant after configuration
// RL19: cascaded memories share output initial value
// RL20: pipeline adds one cycle of read latency
// RL21: write shows new, old, or unchanged output
module dpram_top #(
  parameter          LARGE            = 1,
  parameter          SIMPLE_DUAL      = 0,
  parameter          POWERDOWN_ASYNC  = 0,
  parameter          PORT_CLK_SHARING = `DPRAM_CLK_INDEPENDENT,
  parameter          KEY_SLOT_INDEX   = 1,
  parameter          WIDTH_A          = 0,
  parameter          WIDTH_B          = 0,
  parameter          PIPE_A           = 1,
  parameter          PIPE_B           = 1,
  parameter          PREC_A           = `DPRAM_PREC_RESET,
  parameter          PREC_B           = `DPRAM_PREC_RESET,
  parameter [1:0]    WMODE_A          = `DPRAM_WM_NEW_FIRST,
  parameter [1:0]    WMODE_B          = `DPRAM_WM_NEW_FIRST,
  parameter [1:0]    CASC_A           = `DPRAM_CASC_NONE,
  parameter [1:0]    CASC_B           = `DPRAM_CASC_NONE,
  parameter          ADDR_HOLD_A      = 0,
  parameter          ADDR_HOLD_B      = 0,
  parameter [71:0]   RST_CONST_A      = `DPRAM_CONST_RESET,
  parameter [71:0]   RST_CONST_B      = `DPRAM_CONST_RESET,
  parameter [71:0]   INIT_CONST_A     = `DPRAM_CONST_RESET,
  parameter [71:0]   INIT_CONST_B     = `DPRAM_CONST_RESET,
  parameter [32767:0] CONTENT_INIT    = `DPRAM_CONTENT_RESET,
  parameter [4095:0] PARITY_INIT      = `DPRAM_PARITY_RESET
) (
  input  wire        MCLK,        // shared port clock
  input  wire        RESETN,      // sync reset, active low
  input  wire        POWERDOWN,   // powerdown request pin
  input  wire        A_EN,        // port a enable
  input  wire        A_WE,        // port a write
  input  wire [14:0] A_ADDR,      // port a entry address
  input  wire        A_ADDR_CAP,  // port a address capture enable
  input  wire [63:0] A_DIN,       // port a write data
  input  wire [7:0]  A_PARITY_WRITE_BUS,      // port a write parity
  input  wire        A_OSRST,     // port a output stage reset
  input  wire        A_OCE,       // port a output stage clock enable
  input  wire [71:0] A_CASC_IN,   // port a lower memory output
  input  wire        A_CASC_SEL,  // port a take lower output
  output wire [63:0] A_DOUT,      // port a read data
  output wire [7:0]  A_PARITY_READ_BUS,     // port a read parity
  input  wire        B_EN,        // port b enable
  input  wire        B_WE,        // port b write
  input  wire [14:0] B_ADDR,      // port b entry address
  input  wire        B_ADDR_CAP,  // port b address capture enable
  input  wire [63:0] B_DIN,       // port b write data
  input  wire [7:0]  B_PARITY_WRITE_BUS,      // port b write parity
  input  wire        B_OSRST,     // port b output stage reset
  input  wire        B_OCE,       // port b output stage clock enable
  input  wire [71:0] B_CASC_IN,   // port b lower memory output
  input  wire        B_CASC_SEL,  // port b take lower output
  output wire [63:0] B_DOUT,      // port b read data
  output wire [7:0]  B_PARITY_READ_BUS,     // port b read parity
  output wire        MEM_AWAKE,   // memory out of powerdown
  output wire        CLK_COMMON,  // ports treated as one clock
  output wire        CFG_FAULT    // illegal option combination
);
  function integer wlog;
    input integer w;
    begin
      case (w)
        2:       wlog = 1;
        4:       wlog = 2;
        9:       wlog = 3;
        18:      wlog = 4;
        36:      wlog = 5;
        72:      wlog = 6;
        default: wlog = 0;
      endcase
    end
  endfunction

  function legal_w;
    input integer w;
    input integer top;
    begin
      legal_w = (w == 0) || (w == 1) || (w == 2) || (w == 4) || (w == 9) ||
                (w == 18) || (w == 36 && top >= 36) || (w == 72 && top >= 72);
    end
  endfunction

  localparam WORDS  = LARGE ? `DPRAM_WORDS_LARGE : `DPRAM_WORDS_SMALL;
  localparam [8:0] WMASK = LARGE ? 9'h1ff : 9'h0ff;
  localparam LOG_A  = wlog(WIDTH_A);
  localparam LOG_B  = wlog(WIDTH_B);
  localparam PAR_A  = (WIDTH_A >= 9) ? 1 : 0;
  localparam PAR_B  = (WIDTH_B >= 9) ? 1 : 0;
  localparam PLOG_A = PAR_A ? LOG_A - 3 : 0;
  localparam PLOG_B = PAR_B ? LOG_B - 3 : 0;
  localparam TOP_A  = LARGE ? 36 : 18;
  localparam TOP_B  = SIMPLE_DUAL ? (LARGE ? 72 : 36) : (LARGE ? 36 : 18);
  // widths and simple dual-port restrictions [RL9] [RL10] [RL8]
  localparam FAULT  = !legal_w(WIDTH_A, TOP_A) || !legal_w(WIDTH_B, TOP_B) ||
                      (SIMPLE_DUAL && WIDTH_A != 0) ||
                      (SIMPLE_DUAL && WMODE_A != WMODE_B);
  localparam KEY_SLOT = (KEY_SLOT_INDEX % `DPRAM_KEY_PERIOD) == 0;

  reg [63:0] mem_d [0:`DPRAM_WORDS_LARGE-1];
  reg [7:0]  mem_p [0:`DPRAM_WORDS_LARGE-1];
  integer    i;

  // vector n lands on bits n*256 up; rolling-key slots ignore user content
  initial
  begin
    for (i = 0; i < `DPRAM_WORDS_LARGE; i = i + 1)
    begin
      mem_d[i] = (KEY_SLOT || i >= WORDS) ? 64'h0 : CONTENT_INIT[i*64 +: 64]; // [RL14] [RL15] [RL17]
      mem_p[i] = (KEY_SLOT || i >= WORDS) ? 8'h0 : PARITY_INIT[i*8 +: 8];     // [RL16] [RL17]
    end
  end

  // powerdown: two flops in both modes; async adds a retiming stage
  reg       pd_meta;
  reg       pd_sync;
  reg       pd_samp;
  reg [1:0] wake_cnt;
  wire      pd_now = POWERDOWN_ASYNC ? pd_samp : pd_sync;   // [RL3]

  always @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      pd_meta  <= 1'b0;
      pd_sync  <= 1'b0;
      pd_samp  <= 1'b0;
      wake_cnt <= 2'h0;
    end
    else
    begin
      pd_meta <= POWERDOWN;
      pd_sync <= pd_meta;
      pd_samp <= pd_sync;
      // enables are expected idle here, so no access is lost [RL4]
      if (pd_now)
        wake_cnt <= `DPRAM_WAKE_CYCLES;
      else if (wake_cnt != 2'h0)
        wake_cnt <= wake_cnt - 2'h1;
    end
  end

  assign MEM_AWAKE  = !pd_now && (wake_cnt == 2'h0);
  // single clock here, so only the tied-together case may report common [RL12]
  assign CLK_COMMON = (PORT_CLK_SHARING == `DPRAM_CLK_COMMON);
  assign CFG_FAULT  = FAULT;

  wire        act_a = MEM_AWAKE && (WIDTH_A != 0 || SIMPLE_DUAL) && !FAULT;
  wire        act_b = MEM_AWAKE && (WIDTH_B != 0) && !FAULT;
  wire [14:0] ea_a;
  wire [14:0] ea_b;
  wire [63:0] dm_a;
  wire [63:0] dm_b;
  wire [7:0]  pm_a;
  wire [7:0]  pm_b;
  wire [14:0] bit_a  = ea_a << LOG_A;
  wire [14:0] bit_b  = ea_b << LOG_B;
  wire [11:0] pbit_a = ea_a[11:0] << PLOG_A;
  wire [11:0] pbit_b = ea_b[11:0] << PLOG_B;
  wire [8:0]  wd_a   = bit_a[14:6] & WMASK;
  wire [8:0]  wd_b   = bit_b[14:6] & WMASK;
  wire [8:0]  pw_a   = pbit_a[11:3] & WMASK;
  wire [8:0]  pw_b   = pbit_b[11:3] & WMASK;
  wire [63:0] rw_a   = mem_d[wd_a] >> bit_a[5:0];
  wire [63:0] rw_b   = mem_d[wd_b] >> bit_b[5:0];
  wire [7:0]  rp_a   = mem_p[pw_a] >> pbit_a[2:0];
  wire [7:0]  rp_b   = mem_p[pw_b] >> pbit_b[2:0];
  wire        wr_a   = act_a && A_EN && A_WE && !SIMPLE_DUAL;
  wire        wr_b   = act_b && B_EN && B_WE;

  // port b is applied last, so it wins a same-word collision
  always @(posedge MCLK)
  begin
    if (wr_a)
    begin
      mem_d[wd_a] <= (mem_d[wd_a] & ~(dm_a << bit_a[5:0])) |
                     ((A_DIN & dm_a) << bit_a[5:0]);
      if (PAR_A)
        mem_p[pw_a] <= (mem_p[pw_a] & ~(pm_a << pbit_a[2:0])) |
                       ((A_PARITY_WRITE_BUS & pm_a) << pbit_a[2:0]);
    end
    if (wr_b)
    begin
      mem_d[wd_b] <= (mem_d[wd_b] & ~(dm_b << bit_b[5:0])) |
                     ((B_DIN & dm_b) << bit_b[5:0]);
      if (PAR_B)
        mem_p[pw_b] <= (mem_p[pw_b] & ~(pm_b << pbit_b[2:0])) |
                       ((B_PARITY_WRITE_BUS & pm_b) << pbit_b[2:0]);
    end
  end

  dpram_port #(
    .DW_LOG(LOG_A), .HAS_PAR(PAR_A), .PIPE(PIPE_A), .CE_FIRST(PREC_A),
    .WMODE(WMODE_A), .RST_CONST(RST_CONST_A), .INIT_CONST(INIT_CONST_A),
    .CASC(CASC_A), .ADDR_HOLD(ADDR_HOLD_A)
  ) u_port_a (
    .clk(MCLK), .rst_n(RESETN), .active(act_a), .en(A_EN), .we(wr_a),
    .addr(A_ADDR), .addr_cap(A_ADDR_CAP), .rd_word(rw_a), .rd_par(rp_a),
    .din(A_DIN), .parity_write_bus(A_PARITY_WRITE_BUS), .srst(A_OSRST), .ce(A_OCE),
    .casc_in(A_CASC_IN), .casc_sel(A_CASC_SEL), .eff_addr(ea_a),
    .dmask(dm_a), .pmask(pm_a), .dout(A_DOUT), .parity_read_bus(A_PARITY_READ_BUS)
  );

  dpram_port #(
    .DW_LOG(LOG_B), .HAS_PAR(PAR_B), .PIPE(PIPE_B), .CE_FIRST(PREC_B),
    .WMODE(WMODE_B), .RST_CONST(RST_CONST_B), .INIT_CONST(INIT_CONST_B),
    .CASC(CASC_B), .ADDR_HOLD(ADDR_HOLD_B)
  ) u_port_b (
    .clk(MCLK), .rst_n(RESETN), .active(act_b), .en(B_EN), .we(wr_b),
    .addr(B_ADDR), .addr_cap(B_ADDR_CAP), .rd_word(rw_b), .rd_par(rp_b),
    .din(B_DIN), .parity_write_bus(B_PARITY_WRITE_BUS), .srst(B_OSRST), .ce(B_OCE),
    .casc_in(B_CASC_IN), .casc_sel(B_CASC_SEL), .eff_addr(ea_b),
    .dmask(dm_b), .pmask(pm_b), .dout(B_DOUT), .parity_read_bus(B_PARITY_READ_BUS)
  );
endmodule // dpram_top

`default_nettype wire

// ### dv/dpram_fabric.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_fabric (
  input  wire logic clk,       // port clock
  input  wire logic rst_n,     // bench reset, active low
  input  wire logic req,       // start one sleep cycle
  input  wire logic awake,     // memory awake flag
  output wire logic powerdown, // powerdown pin
  output wire logic busy       // port enables must stay low
);
  logic [3:0] step;
  assign busy = (step != 4'h0);
  // pin high for steps 2..10; caller has enables low a cycle before
  assign powerdown = (step >= 4'h2) && (step <= 4'ha);
  always @(posedge clk)
  begin
    if (!rst_n)
      step <= 4'h0;
    else if (step == 4'h0 && req)
      step <= 4'h1;
    else if (step >= 4'h1 && step < 4'hb)
      step <= step + 4'h1;
    else if (step == 4'hb && awake)
      step <= 4'hc;
    else if (step >= 4'hc && step < 4'he)
      step <= step + 4'h1; // three cycles of margin after wake-up (steps c, d and e)
    else if (step == 4'he)
      step <= 4'h0;
  end
endmodule // dpram_fabric
`default_nettype wire

// ### dv/dpram_props.sv
`timescale 1ns/1ps
`default_nettype none
module dpram_props #(
  parameter        PIPE_A = 1, PIPE_B = 1, PREC_B = 0, PORT_CLK_SHARING = 0,
  parameter [1:0]  WMODE_A = 2'h0,
  parameter [71:0] RST_CONST_A = 72'h0, RST_CONST_B = 72'h0
) (
  input wire        MCLK, RESETN, POWERDOWN, A_EN, A_WE, A_OSRST, B_OSRST, B_OCE,
  input wire [63:0] A_DIN, A_DOUT, B_DOUT,
  input wire        MEM_AWAKE, CLK_COMMON, CFG_FAULT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence s_asleep2; !MEM_AWAKE [*2]; endsequence
  sequence s_wake; ##[1:6] MEM_AWAKE; endsequence
  wire a_wr = A_EN && A_WE && MEM_AWAKE && !CFG_FAULT && !A_OSRST;
  AST_WRITE_NEW_A: assert property (PIPE_A == 0 && WMODE_A == 2'h0 && a_wr |=>
    A_DOUT[7:0] == $past(A_DIN[7:0])) else $error("new data not shown on write");
  AST_OUT_RESET_A: assert property (PIPE_A == 0 && A_OSRST && A_EN && MEM_AWAKE |=>
    A_DOUT[7:0] == RST_CONST_A[7:0]) else $error("latch reset value wrong");
  AST_RESET_B: assert property (PIPE_B == 1 && B_OSRST && MEM_AWAKE &&
    (PREC_B == 0 || B_OCE) |=> B_DOUT[7:0] == RST_CONST_B[7:0])
    else $error("register reset value wrong");
  AST_PREC_CE_B: assert property (PIPE_B == 1 && PREC_B == 1 && B_OSRST && !B_OCE
    |=> $stable(B_DOUT)) else $error("reset acted without clock enable");
  AST_HOLD_B: assert property (PIPE_B == 1 && !B_OCE && !B_OSRST |=>
    $stable(B_DOUT)) else $error("output register moved without enable");
  AST_SLEEP: assert property ($rose(POWERDOWN) |-> ##[1:4] !MEM_AWAKE)
    else $error("memory did not power down");
  AST_WAKE: assert property ($fell(POWERDOWN) && !MEM_AWAKE |->
    s_asleep2 ##0 s_wake) else $error("wake-up timing wrong");
  AST_CLK_SHARE: assert property (CLK_COMMON == (PORT_CLK_SHARING != 0))
    else $error("clock sharing flag wrong");
endmodule // dpram_props
bind dpram_top dpram_props #(.PIPE_A(PIPE_A), .PIPE_B(PIPE_B), .PREC_B(PREC_B),
  .PORT_CLK_SHARING(PORT_CLK_SHARING), .WMODE_A(WMODE_A), .RST_CONST_A(RST_CONST_A),
  .RST_CONST_B(RST_CONST_B)) dpram_props_inst (.MCLK(MCLK), .RESETN(RESETN),
  .POWERDOWN(POWERDOWN), .A_EN(A_EN), .A_WE(A_WE), .A_OSRST(A_OSRST), .B_OSRST(B_OSRST),
  .B_OCE(B_OCE), .A_DIN(A_DIN), .A_DOUT(A_DOUT), .B_DOUT(B_DOUT), .MEM_AWAKE(MEM_AWAKE),
  .CLK_COMMON(CLK_COMMON), .CFG_FAULT(CFG_FAULT));
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpram_consts.vh"
module tb;
  logic        mclk, resetn, sleep_req, slept;
  logic        a_en, a_we, a_cap, a_osrst, b_en, b_we, b_osrst, b_oce;
  logic        a_oce, b_cap, a_csel, b_csel;
  logic [71:0] a_cin, b_cin;
  logic [14:0] a_addr, b_addr;
  logic [63:0] a_din, b_din;
  wire         powerdown, fab_busy, mem_awake, clk_common, cfg_fault;
  wire  [63:0] a_dout, b_dout;
  wire  [7:0]  a_parity_read_bus, b_parity_read_bus;
  integer      fail_count, n_compared, i;
  // old-first on b differs from a: legal only in true dual-port usage
  // no cascade here, so the two initial values may differ
  dpram_top #(.WIDTH_A(36), .WIDTH_B(36), .PIPE_A(0), .PIPE_B(1),
    .PREC_B(`DPRAM_PREC_CLK_EN), .WMODE_B(`DPRAM_WM_OLD_FIRST), .ADDR_HOLD_A(1),
    .PORT_CLK_SHARING(`DPRAM_CLK_COMMON), .RST_CONST_A(72'h00_0000_000a_cafe_f00d),
    .RST_CONST_B(72'h00_0000_0006_0bad_beef), .INIT_CONST_A(72'h00_0000_0009_1234_5678),
    .CONTENT_INIT(32768'h5a5a_0001 << 256), .PARITY_INIT(4096'h5)) dpram_top_inst (
    .MCLK(mclk), .RESETN(resetn), .POWERDOWN(powerdown), .A_EN(a_en), .A_WE(a_we),
    .A_ADDR(a_addr), .A_ADDR_CAP(a_cap), .A_DIN(a_din), .A_PARITY_WRITE_BUS(a_din[7:0]),
    .A_OSRST(a_osrst), .A_OCE(a_oce), .A_CASC_IN(a_cin), .A_CASC_SEL(a_csel),
    .A_DOUT(a_dout), .A_PARITY_READ_BUS(a_parity_read_bus), .B_EN(b_en), .B_WE(b_we), .B_ADDR(b_addr),
    .B_ADDR_CAP(b_cap), .B_DIN(b_din), .B_PARITY_WRITE_BUS(b_din[15:8]), .B_OSRST(b_osrst),
    .B_OCE(b_oce), .B_CASC_IN(b_cin), .B_CASC_SEL(b_csel), .B_DOUT(b_dout),
    .B_PARITY_READ_BUS(b_parity_read_bus), .MEM_AWAKE(mem_awake), .CLK_COMMON(clk_common),
    .CFG_FAULT(cfg_fault));
  dpram_fabric dpram_fabric_inst (.clk(mclk), .rst_n(resetn), .req(sleep_req), .awake(mem_awake),
    .powerdown(powerdown), .busy(fab_busy));
  task check(input logic [63:0] seen, input logic [63:0] expd, input string what);
    n_compared = n_compared + 1;
    if (seen !== expd)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask
  task tick;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    #(2000 * 25);
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial
  begin
    {fail_count, n_compared, slept} = 0;
    {resetn, sleep_req, a_en, a_we, a_osrst, b_en, b_we, b_osrst} = 0;
    {a_cap, b_oce, a_oce, b_cap, a_csel, b_csel} = 6'b111100;
    {a_addr, b_addr, a_din, b_din, a_cin, b_cin} = 0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    check(a_dout[31:0], 64'h1234_5678, "init data");
    check(a_parity_read_bus[3:0], 64'h9, "init parity");
    check(clk_common, 64'h1, "clock sharing");
    check(cfg_fault, 64'h0, "legal widths");
    resetn = 1'b1;
    $display("test reset done");
    a_en = 1'b1;
    a_addr = 15'h0008;
    tick;
    check(a_dout[31:0], 64'h5a5a_0001, "vector one");
    a_addr = 15'h0000;
    tick;
    check(a_parity_read_bus[3:0], 64'h5, "parity vector");
    a_addr = 15'h0001;
    tick;
    check(a_dout[31:0], 64'h0, "zero fill");
    a_addr = 15'h0008;
    tick;
    a_cap = 1'b0;
    a_addr = 15'h0001;
    tick;
    check(a_dout[31:0], 64'h5a5a_0001, "held address");
    $display("test read done");
    {a_cap, a_we, a_addr, a_din} = {1'b1, 1'b1, 15'h0003, 64'h1357_9bdf};
    tick;
    check(a_dout[31:0], 64'h1357_9bdf, "new first");
    {a_en, a_we} = 2'b00;
    {b_en, b_we, b_addr, b_din} = {1'b1, 1'b1, 15'h0003, 64'h2468_ace0};
    tick;
    {b_en, b_we} = 2'b00;
    tick;
    check(b_dout[31:0], 64'h1357_9bdf, "old first");
    b_en = 1'b1;
    tick;
    b_en = 1'b0;
    check(b_dout[31:0], 64'h1357_9bdf, "extra latency");
    tick;
    check(b_dout[31:0], 64'h2468_ace0, "pipelined read");
    check(b_parity_read_bus[3:0], 64'hc, "pipelined parity");
    $display("test write modes done");
    {a_en, a_osrst} = 2'b11;
    tick;
    {a_en, a_osrst} = 2'b00;
    check(a_dout[31:0], 64'hcafe_f00d, "latch reset");
    check(a_parity_read_bus[3:0], 64'ha, "latch reset parity");
    b_oce = 1'b0;
    tick;
    b_osrst = 1'b1;
    tick;
    check(b_dout[31:0], 64'h2468_ace0, "reset without enable");
    b_oce = 1'b1;
    tick;
    b_osrst = 1'b0;
    check(b_dout[31:0], 64'h0bad_beef, "register reset");
    $display("test output reset done");
    sleep_req = 1'b1;
    tick;
    sleep_req = 1'b0;
    for (i = 0; i < 40 && fab_busy; i = i + 1)
    begin
      if (mem_awake === 1'b0)
        slept = 1'b1;
      tick;
    end
    check(slept, 64'h1, "slept");
    check(mem_awake, 64'h1, "woke");
    {a_en, a_addr, a_csel, a_oce} = {1'b1, 15'h0003, 1'b1, 1'b0};
    {b_en, b_addr, b_cap, b_csel} = {1'b1, 15'h0008, 1'b0, 1'b1};
    {a_cin, b_cin} = {72'h00_0000_0000_dead_dead, 72'h00_0000_0000_dead_dead};
    tick;
    {a_en, b_en} = 2'b00;
    check(a_dout[31:0], 64'h2468_ace0, "content kept");
    check(a_parity_read_bus[3:0], 64'hc, "parity kept");
    tick;
    check(b_dout[31:0], 64'h5a5a_0001, "live address");
    $display("test powerdown done");
    give_verdict;
  end
endmodule // tb
`default_nettype wire
